/* verilog/adcsb_top.sv */
// converter sequence control, result buffer and interrupt logic
// assumes a 10 MHz clock, software on the plain register port, and an
// analog front end that returns a code with i_conv_done after o_convert.
//
// Behaviour
// - clearing module enable wipes every result buffer word
// - reference select picks both references, any top-bit code is supply
// - scan enable steps positive input through the scan list on primary_input_mux
// - fill status reads 1 while upper half fills, only in split mode
// - interrupt after every rate plus one completed sequences
// - split mode makes two alternately filled 8-word halves, else 16 words
// - alternate sample uses primary_input_mux first, then B and A in turn
// - alternate sample off always uses primary_input_mux settings
// - unimplemented control bits read zero and ignore writes
`timescale 1ns/1ns
module adcsb_top
  import adcsb_pkg::*;
#(
  parameter int NUM_CH = 16
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_ext_trigger,
  input wire logic i_conv_done,
  input wire logic [9:0] i_conv_code,
  input wire logic [NUM_CH-1:0] i_scan_list,
  input wire logic [3:0] i_primary_input_mux_chan,
  input wire logic [3:0] i_secondary_input_mux_chan,
  output logic o_sampling,
  output logic o_convert,
  output logic [3:0] o_pos_input,
  output logic o_use_secondary_input_mux,
  output logic o_vref_pos_ext,
  output logic o_vref_neg_ext,
  output logic o_irq
);
  import adcsb_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    adcsb_state_t st;
    logic [15:0] c1;
    logic [15:0] c2;
    logic [IRQ_W-1:0] stat;
    logic [IRQ_W-1:0] mask;
    logic [3:0] seq_cnt;
    logic [3:0] wptr;
    logic [3:0] waddr;
    logic [3:0] scan_idx;
    logic alt_b;
    logic [7:0] timer;
    logic rd_buf;
    logic rd_pend;
    logic [15:0] rdata;
    logic sampling;
    logic convert;
    logic [3:0] pos_input;
    logic use_b;
    logic vpos;
    logic vneg;
    logic irq;
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic done_s1;
    logic done_s2;
    logic [9:0] code_s1;
    logic [9:0] code_s2;
  } adcsb_top_st_t;

  adcsb_top_st_t s_q;
  adcsb_top_st_t s_d;

  logic fmt_valid;
  logic [15:0] fmt_word;
  logic [15:0] mem_rdata;
  logic mem_clear;
  logic [3:0] next_scan;
  logic [3:0] first_scan;
  logic [3:0] scan_hit;
  logic found;
  logic [IRQ_W-1:0] ev;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  always_comb begin
    next_scan = s_q.scan_idx;
    found = 1'b0;
    scan_hit = s_q.scan_idx;
    first_scan = '0;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (i_scan_list[k]) begin
        first_scan = 4'(k);
      end
    end
    for (int k = 1; k <= NUM_CH; k++) begin
      scan_hit = 4'(int'(s_q.scan_idx) + k);
      if (!found && i_scan_list[scan_hit]) begin
        next_scan = scan_hit;
        found = 1'b1;
      end
    end
  end

  assign mem_clear = s_q.c1[C1_ENABLE] && i_wr && (i_addr == ADDR_CTRL_ONE)
    && !i_wdata[C1_ENABLE];

  adcsb_fmt u_fmt (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_load(s_q.st == ADCSB_CONVERT && s_q.done_s2),
    .i_format(s_q.c1[C1_OUTPUT_FORMAT_HI:C1_OUTPUT_FORMAT_LO]),
    .i_code(s_q.code_s2),
    .o_valid(fmt_valid),
    .o_word(fmt_word)
  );

  adcsb_mem #(.WIDTH(16), .DEPTH(16), .AW(4)) u_mem (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_clear(mem_clear),
    .i_wr(fmt_valid),
    .i_waddr(s_q.waddr),
    .i_wdata(fmt_word),
    .i_raddr(i_addr[3:0]),
    .o_rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;
    ev = '0;
    s_d.trig_s1 = i_ext_trigger;
    s_d.trig_s2 = s_q.trig_s1;
    s_d.trig_s3 = s_q.trig_s2;
    s_d.done_s1 = i_conv_done;
    s_d.done_s2 = s_q.done_s1;
    s_d.code_s1 = i_conv_code;
    s_d.code_s2 = s_q.code_s1;
    s_d.rd_buf = 1'b0;
    s_d.rd_pend = 1'b0;

    // register writes
    if (i_wr && i_addr == ADDR_CTRL_ONE) begin
      s_d.c1 = (i_wdata & C1_WMASK) | (s_q.c1 & ~C1_WMASK);
      if (i_wdata[C1_DONE] == 1'b0) begin
        s_d.c1[C1_DONE] = 1'b0;
      end else begin
        s_d.c1[C1_DONE] = s_q.c1[C1_DONE];
      end
    end else if (i_wr && i_addr == ADDR_CTRL_TWO) begin
      s_d.c2 = (i_wdata & C2_WMASK) | (s_q.c2 & ~C2_WMASK);
    end else if (i_wr && i_addr == ADDR_IRQ_MASK) begin
      s_d.mask = i_wdata[IRQ_W-1:0];
    end

    // sequencer
    case (s_q.st)
      ADCSB_IDLE: begin
        if (s_d.c1[C1_ENABLE] && s_d.c1[C1_SAMPLE]) begin
          s_d.st = ADCSB_SAMPLE;
          s_d.timer = '0;
        end
      end
      ADCSB_SAMPLE: begin
        s_d.timer = s_q.timer + 8'h01;
        if (!s_d.c1[C1_ENABLE]) begin
          s_d.st = ADCSB_IDLE;
        end else if ((s_q.c1[C1_TRIG_HI:C1_TRIG_LO] == TRIG_MANUAL
            && !s_d.c1[C1_SAMPLE])
            || (s_q.c1[C1_TRIG_HI:C1_TRIG_LO] == TRIG_AUTO
            && s_q.timer == 8'(AUTO_SAMPLE_CYCLES - 1))
            || (s_q.c1[C1_TRIG_HI:C1_TRIG_LO] != TRIG_MANUAL
            && s_q.c1[C1_TRIG_HI:C1_TRIG_LO] != TRIG_AUTO
            && s_q.trig_s2 && !s_q.trig_s3)) begin
          s_d.st = ADCSB_CONVERT;
          s_d.c1[C1_SAMPLE] = 1'b0;
          s_d.c1[C1_DONE] = 1'b0;
        end
      end
      default: begin
        if (!s_d.c1[C1_ENABLE]) begin
          s_d.st = ADCSB_IDLE;
        end else if (s_q.done_s2) begin
          // formatted word lands a cycle later, keep its slot
          s_d.waddr = s_q.wptr;
          s_d.c1[C1_DONE] = 1'b1;
          ev[IRQ_CONV] = 1'b1;
          if (s_q.c1[C1_AUTO]) begin
            s_d.c1[C1_SAMPLE] = 1'b1;
            s_d.st = ADCSB_SAMPLE;
            s_d.timer = '0;
          end else begin
            s_d.st = ADCSB_IDLE;
          end
          if (s_q.c2[C2_ALT]) begin
            s_d.alt_b = ~s_q.alt_b;
          end else begin
            s_d.alt_b = 1'b0;
          end
          if (s_q.c2[C2_SCAN] && !s_q.alt_b) begin
            s_d.scan_idx = next_scan;
          end
          if (s_q.seq_cnt == s_q.c2[C2_RATE_HI:C2_RATE_LO]) begin
            s_d.seq_cnt = '0;
            ev[IRQ_SEQ] = 1'b1;
            if (s_q.c2[C2_SPLIT]) begin
              s_d.c2[C2_FILL] = ~s_q.c2[C2_FILL];
              s_d.wptr = s_d.c2[C2_FILL] ? 4'h8 : 4'h0;
            end else begin
              s_d.wptr = '0;
            end
          end else begin
            s_d.seq_cnt = s_q.seq_cnt + 4'h1;
            s_d.wptr = s_q.c2[C2_SPLIT]
              ? {s_q.wptr[3], s_q.wptr[2:0] + 3'h1}
              : s_q.wptr + 4'h1;
          end
        end
      end
    endcase

    // fill status is only meaningful in split mode
    if (!s_d.c2[C2_SPLIT]) begin
      s_d.c2[C2_FILL] = 1'b0;
    end
    if (!s_d.c1[C1_ENABLE]) begin
      s_d.seq_cnt = '0;
      s_d.wptr = '0;
      s_d.alt_b = 1'b0;
      s_d.c2[C2_FILL] = 1'b0;
    end
    if (!s_d.c2[C2_ALT]) begin
      s_d.alt_b = 1'b0;
    end
    // scan starts from the lowest listed input
    if (!s_d.c2[C2_SCAN] || !s_d.c1[C1_ENABLE]) begin
      s_d.scan_idx = first_scan;
    end

    // sticky status, set wins over write-one clear
    if (i_wr && i_addr == ADDR_IRQ_STAT) begin
      s_d.stat = s_q.stat & ~i_wdata[IRQ_W-1:0];
    end
    s_d.stat = s_d.stat | ev;

    // reads
    s_d.rdata = '0;
    if (i_rd) begin
      if (i_addr == ADDR_CTRL_ONE) begin
        s_d.rdata = s_q.c1;
      end else if (i_addr == ADDR_CTRL_TWO) begin
        s_d.rdata = s_q.c2;
      end else if (i_addr == ADDR_IRQ_STAT) begin
        s_d.rdata = 16'(s_q.stat);
      end else if (i_addr == ADDR_IRQ_MASK) begin
        s_d.rdata = 16'(s_q.mask);
      end else if (i_addr[4]) begin
        s_d.rd_buf = 1'b1;
      end
    end

    // outputs
    s_d.sampling = (s_d.st == ADCSB_SAMPLE);
    s_d.convert = (s_d.st == ADCSB_CONVERT);
    s_d.use_b = s_d.alt_b;
    s_d.pos_input = s_d.alt_b ? i_secondary_input_mux_chan
      : (s_d.c2[C2_SCAN] ? s_d.scan_idx : i_primary_input_mux_chan);
    case (s_d.c2[C2_REF_HI:C2_REF_LO])
      3'h1: begin
        s_d.vpos = 1'b1;
        s_d.vneg = 1'b0;
      end
      3'h2: begin
        s_d.vpos = 1'b0;
        s_d.vneg = 1'b1;
      end
      3'h3: begin
        s_d.vpos = 1'b1;
        s_d.vneg = 1'b1;
      end
      default: begin
        s_d.vpos = 1'b0;
        s_d.vneg = 1'b0;
      end
    endcase
    s_d.irq = |(s_d.stat & s_d.mask);
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
      s_q.st <= ADCSB_IDLE;
      s_q.c1 <= C1_RESET;
      s_q.c2 <= C2_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rd_buf ? mem_rdata : s_q.rdata;
  assign o_sampling = s_q.sampling;
  assign o_convert = s_q.convert;
  assign o_pos_input = s_q.pos_input;
  assign o_use_secondary_input_mux = s_q.use_b;
  assign o_vref_pos_ext = s_q.vpos;
  assign o_vref_neg_ext = s_q.vneg;
  assign o_irq = s_q.irq;

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_unimpl_zero;
    @(posedge i_clock) disable iff (!i_arst_n)
      ((s_q.c1 & ~C1_WMASK & 16'hFFFE) == 16'h0000)
      && ((s_q.c2 & ~C2_WMASK & 16'hFF7F) == 16'h0000);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented control bit set");

  property p_ref_ext;
    @(posedge i_clock) disable iff (!i_arst_n)
      s_q.c2[C2_REF_HI] |-> !o_vref_pos_ext && !o_vref_neg_ext;
  endproperty
  a_ref_ext: assert property (p_ref_ext)
    else $error("top reference code did not select supply");

  property p_fill_split;
    @(posedge i_clock) disable iff (!i_arst_n)
      !s_q.c2[C2_SPLIT] |-> !s_q.c2[C2_FILL];
  endproperty
  a_fill_split: assert property (p_fill_split)
    else $error("fill status set outside split mode");

  property p_rate;
    @(posedge i_clock) disable iff (!i_arst_n)
      s_q.seq_cnt > s_q.c2[C2_RATE_HI:C2_RATE_LO] |-> !ev[IRQ_SEQ];
  endproperty
  a_rate: assert property (p_rate)
    else $error("sequence interrupt at wrong count");

  property p_split_half;
    @(posedge i_clock) disable iff (!i_arst_n)
      s_q.c2[C2_SPLIT] && s_q.c1[C1_ENABLE] && fmt_valid
      |-> s_q.waddr[3] == $past(s_q.c2[C2_FILL]);
  endproperty
  a_split_half: assert property (p_split_half)
    else $error("write into half not being filled");

  property p_alt_off;
    @(posedge i_clock) disable iff (!i_arst_n)
      !s_q.c2[C2_ALT] |-> !o_use_secondary_input_mux;
  endproperty
  a_alt_off: assert property (p_alt_off)
    else $error("secondary_input_mux used while alternate sample off");

  sequence s_conv_end;
    s_q.st == ADCSB_CONVERT && s_q.done_s2 && s_q.c1[C1_AUTO]
      && s_d.c1[C1_ENABLE];
  endsequence
  property p_auto;
    @(posedge i_clock) disable iff (!i_arst_n)
      s_conv_end |=> s_q.c1[C1_SAMPLE] && o_sampling;
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto sample did not restart sampling");

  property p_disable_clear;
    @(posedge i_clock) disable iff (!i_arst_n)
      mem_clear |=> s_q.wptr == 4'h0 && !s_q.c1[C1_ENABLE];
  endproperty
  a_disable_clear: assert property (p_disable_clear)
    else $error("disable did not reset buffer state");

  property p_alt_first;
    @(posedge i_clock) disable iff (!i_arst_n)
      $fell(s_q.c1[C1_ENABLE]) |-> !s_q.alt_b;
  endproperty
  a_alt_first: assert property (p_alt_first)
    else $error("first sample after disable not on primary_input_mux");

endmodule // adcsb_top

/* verilog/adcsb_pkg.sv */
// package for the converter sequence and result buffer control
// assumes a single 10 MHz clock domain shared by all design files
package adcsb_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register indices (word addresses on the plain register port)
  localparam logic [4:0] ADDR_CTRL_ONE = 5'h00;
  localparam logic [4:0] ADDR_CTRL_TWO = 5'h01;
  localparam logic [4:0] ADDR_IRQ_STAT = 5'h02;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h03;
  localparam logic [4:0] ADDR_BUF_BASE = 5'h10;

  ////////////////////////////////////////////////////////////////////////
  // control one fields
  localparam int C1_ENABLE = 15;
  localparam int C1_OUTPUT_FORMAT_HI = 9;
  localparam int C1_OUTPUT_FORMAT_LO = 8;
  localparam int C1_TRIG_HI = 7;
  localparam int C1_TRIG_LO = 5;
  localparam int C1_AUTO = 2;
  localparam int C1_SAMPLE = 1;
  localparam int C1_DONE = 0;
  localparam logic [15:0] C1_WMASK = 16'h83E6;
  localparam logic [15:0] C1_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // control two fields
  localparam int C2_REF_HI = 15;
  localparam int C2_REF_LO = 13;
  localparam int C2_SCAN = 10;
  localparam int C2_FILL = 7;
  localparam int C2_RATE_HI = 5;
  localparam int C2_RATE_LO = 2;
  localparam int C2_SPLIT = 1;
  localparam int C2_ALT = 0;
  localparam logic [15:0] C2_WMASK = 16'hE43F;
  localparam logic [15:0] C2_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // interrupt status bits
  localparam int IRQ_SEQ = 0;
  localparam int IRQ_CONV = 1;
  localparam int IRQ_W = 2;

  ////////////////////////////////////////////////////////////////////////
  // trigger sources, formats, timing
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  localparam logic [1:0] FMT_UINT = 2'h0;
  localparam logic [1:0] FMT_SINT = 2'h1;
  localparam logic [1:0] FMT_FRAC = 2'h2;
  localparam logic [1:0] FMT_SFRAC = 2'h3;
  localparam int CONV_TIME_NS = 1200;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int AUTO_SAMPLE_CYCLES = 4;

  typedef enum logic [2:0] {
    ADCSB_IDLE = 3'b001,
    ADCSB_SAMPLE = 3'b010,
    ADCSB_CONVERT = 3'b100
  } adcsb_state_t;

endpackage

/* verilog/adcsb_mem.sv */
// result buffer storage, sixteen words, registered read port
// assumes a synchronous clear pulse from the control logic
`timescale 1ns/1ns
module adcsb_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_clear,
  input wire logic i_wr,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd;
  } adcsb_mem_st_t;

  adcsb_mem_st_t s_q;
  adcsb_mem_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.rd = s_q.mem[i_raddr];
    if (i_clear) begin
      s_d.mem = '0;
    end else if (i_wr) begin
      s_d.mem[i_waddr] = i_wdata;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rd;
endmodule // adcsb_mem

/* verilog/adcsb_fmt.sv */
// result formatter: 10-bit code to the selected 16-bit presentation
// assumes the raw code is held stable while i_load is high
`timescale 1ns/1ns
module adcsb_fmt
  import adcsb_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_load,
  input wire logic [1:0] i_format,
  input wire logic [9:0] i_code,
  output logic o_valid,
  output logic [15:0] o_word
);
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } adcsb_fmt_st_t;

  adcsb_fmt_st_t s_q;
  adcsb_fmt_st_t s_d;
  logic [9:0] signed_code;

  always_comb begin
    s_d = s_q;
    s_d.valid = i_load;
    signed_code = {~i_code[9], i_code[8:0]};
    if (i_load) begin
      case (i_format)
        FMT_UINT: s_d.word = {6'h00, i_code};
        FMT_SINT: s_d.word = {{6{signed_code[9]}}, signed_code};
        FMT_FRAC: s_d.word = {i_code, 6'h00};
        default: s_d.word = {signed_code, 6'h00};
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_valid = s_q.valid;
  assign o_word = s_q.word;
endmodule // adcsb_fmt

/* dv/adcsb_afe_model.sv */
// analog front end model: answers each conversion request with a code
// assumes the block holds o_convert high until it has taken the answer
`timescale 1ns/1ns
module adcsb_afe_model (
  input wire logic i_clock,
  input wire logic i_convert,
  input wire logic [3:0] i_delay,
  input wire logic [9:0] i_code,
  output logic o_done,
  output logic [9:0] o_code
);
  logic [3:0] cnt_q;

  initial begin
    o_done = 1'b0;
    o_code = 10'h2AA;
    cnt_q = 4'h0;
  end

  // code line toggles whenever no answer is held, so stale values never match
  always @(posedge i_clock) begin
    if (!i_convert) begin
      cnt_q <= 4'h0;
      o_done <= 1'b0;
      o_code <= ~o_code;
    end else if (cnt_q == i_delay) begin
      o_done <= 1'b1;
      o_code <= i_code;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      o_code <= ~o_code;
    end
  end
endmodule // adcsb_afe_model

/* dv/testbench.sv */
// self-checking bench for the converter sequence and result buffer
// assumes the front end model of adcsb_afe_model beside the block
`timescale 1ns/1ns
module testbench;
  import adcsb_pkg::*;
  logic i_clock, i_arst_n, i_wr, i_rd, done, trig;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, rv, scan_list;
  logic [9:0] code, code_sel;
  logic [3:0] primary_input_mux, secondary_input_mux, pos, pos_seen, dly;
  logic sampling, convert, use_b, b_seen, vp, vn, irq;
  int errors, compares;

  adcsb_top i_adcsb_top (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(rdata), .i_ext_trigger(trig), .i_conv_done(done),
    .i_conv_code(code), .i_scan_list(scan_list), .i_primary_input_mux_chan(primary_input_mux),
    .i_secondary_input_mux_chan(secondary_input_mux), .o_sampling(sampling), .o_convert(convert),
    .o_pos_input(pos), .o_use_secondary_input_mux(use_b), .o_vref_pos_ext(vp),
    .o_vref_neg_ext(vn), .o_irq(irq));
  adcsb_afe_model i_adcsb_afe_model (.i_clock(i_clock),
    .i_convert(convert), .i_delay(dly), .i_code(code_sel),
    .o_done(done), .o_code(code));

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge i_clock);
    i_rd <= 1'b1;
    addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 rv = rdata;
  endtask

  // one software-started sequence; keeps the input settings seen
  task automatic conv(input logic [15:0] base, input logic [9:0] c);
    code_sel = c;
    wr(ADDR_CTRL_ONE, base | 16'h0002);
    repeat (2) @(posedge i_clock);
    wr(ADDR_CTRL_ONE, base);
    for (int i = 0; i < 20 && convert !== 1'b1; i++) begin
      @(posedge i_clock);
      #1;
    end
    pos_seen = pos;
    b_seen = use_b;
    for (int i = 0; i < 40 && convert !== 1'b0; i++) begin
      @(posedge i_clock);
      #1;
    end
    repeat (4) @(posedge i_clock);
  endtask

  function automatic logic [15:0] fmt(input logic [1:0] f,
                                       input logic [9:0] c);
    logic s;
    s = ~c[9];
    case (f)
      FMT_UINT: fmt = {6'h00, c};
      FMT_SINT: fmt = {{7{s}}, c[8:0]};
      FMT_FRAC: fmt = {c, 6'h00};
      default: fmt = {s, c[8:0], 6'h00};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    wr(ADDR_CTRL_ONE, 16'h7C18);
    rd(ADDR_CTRL_ONE);
    chk("ctrl_one", 16'h0000, rv);
    wr(ADDR_CTRL_TWO, 16'hFFFF);
    rd(ADDR_CTRL_TWO);
    chk("ctrl_two", C2_WMASK, rv);
    for (int r = 0; r < 8; r++) begin
      wr(ADDR_CTRL_TWO, 16'(r) << C2_REF_LO);
      repeat (2) @(posedge i_clock);
      chk("vref_pos", 16'(r == 1 || r == 3), 16'(vp));
      chk("vref_neg", 16'(r == 2 || r == 3), 16'(vn));
    end
  endtask

  task automatic t_format();
    wr(ADDR_CTRL_TWO, 16'h000C);
    for (int f = 0; f < 4; f++)
      conv(16'h8000 | (16'(f) << C1_OUTPUT_FORMAT_LO), 10'h0C5 + 10'(f * 'h111));
    for (int f = 0; f < 4; f++) begin
      rd(ADDR_BUF_BASE + 5'(f));
      chk("word", fmt(2'(f), 10'h0C5 + 10'(f * 'h111)), rv);
    end
    rd(ADDR_BUF_BASE);
    chk("kept", fmt(FMT_UINT, 10'h0C5), rv);
    wr(ADDR_CTRL_ONE, 16'h0000);
    rd(ADDR_BUF_BASE + 5'h01);
    chk("wiped", 16'h0000, rv);
  endtask

  task automatic t_irq();
    wr(ADDR_CTRL_TWO, 16'h0008);
    wr(ADDR_IRQ_STAT, 16'h0003);
    wr(ADDR_IRQ_MASK, 16'h0001);
    conv(16'h8000, 10'h011);
    conv(16'h8000, 10'h022);
    chk("irq_early", 16'h0000, 16'(irq));
    conv(16'h8000, 10'h033);
    chk("irq_rate", 16'h0001, 16'(irq));
    rd(ADDR_IRQ_STAT);
    chk("stat", 16'h0003, rv);
    wr(ADDR_IRQ_STAT, 16'h0001);
    repeat (2) @(posedge i_clock);
    chk("irq_clear", 16'h0000, 16'(irq));
    wr(ADDR_CTRL_ONE, 16'h0000);
  endtask

  task automatic t_mux();
    wr(ADDR_CTRL_TWO, 16'h0001);
    for (int k = 0; k < 3; k++) begin
      conv(16'h8000, 10'h100);
      chk("alt_b", 16'(k == 1), 16'(b_seen));
      chk("alt_pos", 16'(k == 1 ? secondary_input_mux : primary_input_mux), 16'(pos_seen));
    end
    wr(ADDR_CTRL_TWO, 16'h0000);
    conv(16'h8000, 10'h101);
    chk("single_b", 16'h0000, 16'(b_seen));
    chk("single_pos", 16'(primary_input_mux), 16'(pos_seen));
    wr(ADDR_CTRL_TWO, 16'h0400);
    conv(16'h8000, 10'h102);
    chk("scan_in", 16'h0001, 16'(scan_list[pos_seen]));
    chk("scan_first", 16'h0002, 16'(pos_seen));
    conv(16'h8000, 10'h103);
    chk("scan_in", 16'h0001, 16'(scan_list[pos_seen]));
    chk("scan_step", 16'h0005, 16'(pos_seen));
    wr(ADDR_CTRL_ONE, 16'h0000);
  endtask

  task automatic t_split();
    wr(ADDR_CTRL_TWO, 16'h001E);
    for (int k = 0; k < 8; k++) conv(16'h8000, 10'h200 + 10'(k));
    rd(ADDR_CTRL_TWO);
    chk("fill_status", 16'h009E, rv);
    rd(ADDR_BUF_BASE + 5'h07);
    chk("low_half", 16'h0207, rv);
    for (int k = 8; k < 16; k++) conv(16'h8000, 10'h200 + 10'(k));
    rd(ADDR_CTRL_TWO);
    chk("fill_status", 16'h001E, rv);
    rd(ADDR_BUF_BASE + 5'h08);
    chk("high_half", 16'h0208, rv);
    wr(ADDR_CTRL_ONE, 16'h0000);
  endtask

  task automatic t_auto();
    wr(ADDR_CTRL_TWO, 16'h0000);
    dly = 4'h6;
    wr(ADDR_CTRL_ONE, 16'h8006 | (16'(TRIG_AUTO) << C1_TRIG_LO));
    for (int i = 0; i < 30 && convert !== 1'b1; i++) begin
      @(posedge i_clock);
      #1;
    end
    for (int i = 0; i < 40 && convert !== 1'b0; i++) begin
      @(posedge i_clock);
      #1;
    end
    chk("resample", 16'h0001, 16'(sampling));
    rd(ADDR_CTRL_ONE);
    chk("sample_bit", 16'h0001, 16'(rv[C1_SAMPLE]));
    wr(ADDR_CTRL_ONE, 16'h0000);
    dly = 4'h2;
  endtask

  // external edge ends sampling when the trigger select is 1
  task automatic t_trig();
    wr(ADDR_CTRL_TWO, 16'h0000);
    wr(ADDR_CTRL_ONE, 16'h8022);
    repeat (4) @(posedge i_clock);
    chk("no_trigger", 16'h0000, 16'(convert));
    trig <= 1'b1;
    repeat (6) @(posedge i_clock);
    trig <= 1'b0;
    #1;
    chk("trigger", 16'h0001, 16'(convert));
    for (int i = 0; i < 20 && convert !== 1'b0; i++) begin
      @(posedge i_clock);
      #1;
    end
    chk("trig_idle", 16'h0000, 16'(sampling));
    wr(ADDR_CTRL_ONE, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  initial begin
    #2000000;
    errors++;
    complete_run();
  end

  initial begin
    errors = 0;
    compares = 0;
    i_arst_n = 1'b0;
    {i_wr, i_rd, trig} = 3'b000;
    addr = 5'h00;
    wdata = 16'h0000;
    code_sel = 10'h000;
    scan_list = 16'h0024;
    primary_input_mux = 4'h3;
    secondary_input_mux = 4'h9;
    dly = 4'h2;
    repeat (6) @(posedge i_clock);
    i_arst_n <= 1'b1;
    t_regs();
    t_format();
    t_irq();
    t_mux();
    t_split();
    t_auto();
    t_trig();
    complete_run();
  end
endmodule // testbench
